// File: bench/oifsel_props.sv
`timescale 1ns/1ps
module oifsel_props (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic [11:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic [2:0] FUSE_MAP_VARIANT,
  input wire logic [2:0] FUSE_LANE_MODE,
  input wire logic [2:0] ACTIVE_MAP_VARIANT,
  input wire logic [2:0] ACTIVE_LANE_MODE,
  input wire logic DEFAULTS_RESTORE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  wire cw = REG_WR && REG_ADDR == 12'h007;
  wire [2:0] sel = REG_WDATA[2:0];
  wire ok = sel inside {3'h3, 3'h4, 3'h5};
  wire ld = ACTIVE_LANE_MODE == FUSE_LANE_MODE;
  wire md = ACTIVE_MAP_VARIANT == FUSE_MAP_VARIANT;
  sequence restore_s;
    DEFAULTS_RESTORE ##1 ld;
  endsequence
  lane_sel_a: assert property (cw && REG_WDATA[3] && ok |=> ACTIVE_LANE_MODE == $past(sel))
    else $error("lane select lost");
  lane_dflt_a: assert property (cw && !REG_WDATA[3] |=> ld)
    else $error("lane default lost");
  lane_bad_a: assert property (cw && REG_WDATA[3] && !ok |=> $stable(ACTIVE_LANE_MODE))
    else $error("unused lane code applied");
  map_hold_a: assert property (cw |=> $stable(ACTIVE_MAP_VARIANT))
    else $error("mapper changed early");
  reload_a: assert property (REG_WR && REG_ADDR == 12'h013 && REG_WDATA[0] |-> restore_s)
    else $error("reload missed");
  swrst_a: assert property (REG_WR && REG_ADDR == 12'h000 && REG_WDATA[0] |-> DEFAULTS_RESTORE ##2 (ld && md))
    else $error("soft reset missed");
  boot_a: assert property ($rose(RST_B) |=> ld && md)
    else $error("fuse defaults missing");
  rd_zero_a: assert property (REG_RD && REG_ADDR != 12'h007 |=> REG_RDATA == 8'h00)
    else $error("self clear bit reads set");
endmodule
bind oifsel_top oifsel_props i_props (.*);

// File: bench/output_interface_select_reg_bench.sv
`timescale 1ns/1ps
module output_interface_select_reg_bench;
  logic CLOCK = 0, RST_B = 0, REG_WR = 0, REG_RD = 0, DEFAULTS_RESTORE;
  logic [11:0] REG_ADDR = 0;
  logic [7:0] REG_WDATA = 0, REG_RDATA, q;
  logic [2:0] FUSE_MAP_VARIANT = 3'h2, FUSE_LANE_MODE = 3'h3, ACTIVE_MAP_VARIANT, ACTIVE_LANE_MODE;
  int error_cnt = 0, comparisons = 0;
  // config byte, then lane mode it should leave in force
  logic [10:0] rows [8] = '{11'h064, 11'h06D, 11'h075, 11'h05B, 11'h06D, 11'h045, 11'h02B, 11'h303};
  oifsel_top i_dut (.*);
  always #20 CLOCK = ~CLOCK;
  task summarize();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge CLOCK) {REG_WR, REG_ADDR, REG_WDATA} <= {1'h1, a, d};
    @(posedge CLOCK) REG_WR <= 1'h0;
    #1;
  endtask
  task rd(input logic [11:0] a);
    @(posedge CLOCK) {REG_RD, REG_ADDR} <= {1'h1, a};
    @(posedge CLOCK) REG_RD <= 1'h0;
    #1 q = REG_RDATA;
  endtask
  initial begin
    repeat (2) @(posedge CLOCK);
    RST_B <= 1'h1;
    @(posedge CLOCK);
    rd(12'h007);
    chk(q, 8'h00);
    chk({5'h00, ACTIVE_LANE_MODE}, 8'h03);
    chk({5'h00, ACTIVE_MAP_VARIANT}, 8'h02);
    foreach (rows[i]) begin
      wr(12'h007, rows[i][10:3]);
      chk({5'h00, ACTIVE_LANE_MODE}, {5'h00, rows[i][2:0]});
      chk({5'h00, ACTIVE_MAP_VARIANT}, 8'h02);
      rd(12'h007);
      chk(q, rows[i][10:3]);
    end
    wr(12'h013, 8'h01);
    chk({5'h00, ACTIVE_MAP_VARIANT}, 8'h03);
    rd(12'h007);
    chk(q, 8'h00);
    wr(12'h000, 8'h01);
    // soft reset lands one cycle later than a reload
    @(posedge CLOCK) #1;
    chk({5'h00, ACTIVE_MAP_VARIANT}, 8'h02);
    rd(12'h000);
    chk(q, 8'h00);
    rd(12'h055);
    chk(q, 8'h00);
    summarize();
  end
  initial begin
    #20000;
    error_cnt++;
    summarize();
  end
endmodule

// File: design/oifsel_code_hold.sv
`timescale 1ns/1ps
// holds one active three-bit interface code; candidates outside [lo_code, hi_code] are ignored
module oifsel_code_hold
  import oifsel_pkg::*;
#(
  parameter logic [2:0] LO_CODE = 3'h1,
  parameter logic [2:0] HI_CODE = 3'h4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic load_default,
  input wire logic [2:0] default_code,
  input wire logic load_new,
  input wire logic [2:0] new_code,
  output logic [2:0] code
);
  logic [2:0] code_reg;
  logic [2:0] code_next;
  wire new_ok = (new_code >= LO_CODE) && (new_code <= HI_CODE);

  always_comb begin
    code_next = code_reg;
    if (load_default) begin
      code_next = default_code;
    end else if (load_new && new_ok) begin
      code_next = new_code;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      code_reg <= OIFSEL_CODE_RESET;
    end else begin
      code_reg <= code_next;
    end
  end

  assign code = code_reg;
endmodule

// File: design/oifsel_pkg.sv
package oifsel_pkg;
  localparam logic [11:0] OIFSEL_ADDR_SWRST = 12'h000;
  localparam logic [11:0] OIFSEL_ADDR_CFG = 12'h007;
  localparam logic [11:0] OIFSEL_ADDR_FUSE_LD = 12'h013;
  localparam int OIFSEL_SWRST_BIT = 0;
  localparam int OIFSEL_FUSE_LD_BIT = 0;
  localparam int OIFSEL_MAP_LSB = 5;
  localparam int OIFSEL_MAP_MSB = 7;
  localparam int OIFSEL_EN_BIT = 3;
  localparam int OIFSEL_SEL_LSB = 0;
  localparam int OIFSEL_SEL_MSB = 2;
  localparam logic [7:0] OIFSEL_CFG_RESET = 8'h00;
  localparam logic [2:0] OIFSEL_CODE_RESET = 3'h0;
  // bit-mapping variant codes
  localparam logic [2:0] OIFSEL_MAP_2L_18_14 = 3'h1;
  localparam logic [2:0] OIFSEL_MAP_2L_16 = 3'h2;
  localparam logic [2:0] OIFSEL_MAP_1L = 3'h3;
  localparam logic [2:0] OIFSEL_MAP_HALF = 3'h4;
  // lane-mode codes
  localparam logic [2:0] OIFSEL_LANE_2L = 3'h3;
  localparam logic [2:0] OIFSEL_LANE_1L = 3'h4;
  localparam logic [2:0] OIFSEL_LANE_HALF = 3'h5;
endpackage

// File: design/oifsel_top.sv
`timescale 1ns/1ps
// Behaviour
// - Mapper codes: 001 two-lane 18/14-bit, 010 two-lane 16-bit, 011 one-lane, 100 half-lane, others unused.
// - A written mapper value becomes active only when the fuse reload command is later issued.
// - The fuse reload command makes a pending written mapper value active and returns all other serially written values to their defaults.
// - After reset the fuse default mapper is applied without any write.
// - Readback of this register is 000 in both fields until software writes it.
// - The override enable lets the lane-mode select replace the fuse default; clear keeps the default.
// - Lane-mode codes: 011 two-lane, 100 one-lane, 101 half-lane, others unused.
// - The software reset bit returns all registers to defaults and then reads back 0.
module oifsel_top
  import oifsel_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic [11:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic [2:0] FUSE_MAP_VARIANT,
  input wire logic [2:0] FUSE_LANE_MODE,
  output logic [2:0] ACTIVE_MAP_VARIANT,
  output logic [2:0] ACTIVE_LANE_MODE,
  output logic DEFAULTS_RESTORE
);
  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;
  logic [2:0] map_pend_reg;
  logic [2:0] map_pend_next;
  logic map_pend_valid_reg;
  logic map_pend_valid_next;
  logic init_pending_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // write decode
  wire wr_cfg = REG_WR && (REG_ADDR == OIFSEL_ADDR_CFG);
  wire wr_swrst = REG_WR && (REG_ADDR == OIFSEL_ADDR_SWRST) && REG_WDATA[OIFSEL_SWRST_BIT];
  wire wr_fuse = REG_WR && (REG_ADDR == OIFSEL_ADDR_FUSE_LD) && REG_WDATA[OIFSEL_FUSE_LD_BIT];
  wire [2:0] wr_map = REG_WDATA[OIFSEL_MAP_MSB:OIFSEL_MAP_LSB];
  wire wr_map_ok = (wr_map >= OIFSEL_MAP_2L_18_14) && (wr_map <= OIFSEL_MAP_HALF);
  wire wr_en = REG_WDATA[OIFSEL_EN_BIT];
  wire [2:0] wr_sel = REG_WDATA[OIFSEL_SEL_MSB:OIFSEL_SEL_LSB];
  wire clear_writes = wr_swrst || wr_fuse;

  // fuse defaults are applied one cycle after reset release or a software reset
  wire map_load_default = init_pending_reg || (wr_fuse && !map_pend_valid_reg);
  wire map_load_new = wr_fuse && map_pend_valid_reg && !init_pending_reg;
  wire lane_load_default = init_pending_reg || wr_fuse || (wr_cfg && !wr_en);
  wire lane_load_new = wr_cfg && wr_en;

  always_comb begin
    cfg_next = cfg_reg;
    map_pend_next = map_pend_reg;
    map_pend_valid_next = map_pend_valid_reg;
    if (clear_writes) begin
      cfg_next = OIFSEL_CFG_RESET;
      map_pend_next = OIFSEL_CODE_RESET;
      map_pend_valid_next = 1'b0;
    end else if (wr_cfg) begin
      cfg_next = REG_WDATA;
      if (wr_map_ok) begin
        map_pend_next = wr_map;
        map_pend_valid_next = 1'b1;
      end
    end
  end

  // readback shows only what was written, never the fuse value in force
  assign rdata_next = (REG_RD && (REG_ADDR == OIFSEL_ADDR_CFG)) ? cfg_reg : 8'h00;

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      cfg_reg <= OIFSEL_CFG_RESET;
      map_pend_reg <= OIFSEL_CODE_RESET;
      map_pend_valid_reg <= 1'b0;
      init_pending_reg <= 1'b1;
      rdata_reg <= 8'h00;
    end else begin
      cfg_reg <= cfg_next;
      map_pend_reg <= map_pend_next;
      map_pend_valid_reg <= map_pend_valid_next;
      init_pending_reg <= wr_swrst;
      rdata_reg <= rdata_next;
    end
  end

  oifsel_code_hold #(
    .LO_CODE(OIFSEL_MAP_2L_18_14),
    .HI_CODE(OIFSEL_MAP_HALF)
  ) u_map_hold (
    .clk(CLOCK),
    .rst_b(RST_B),
    .load_default(map_load_default),
    .default_code(FUSE_MAP_VARIANT),
    .load_new(map_load_new),
    .new_code(map_pend_reg),
    .code(ACTIVE_MAP_VARIANT)
  );

  oifsel_code_hold #(
    .LO_CODE(OIFSEL_LANE_2L),
    .HI_CODE(OIFSEL_LANE_HALF)
  ) u_lane_hold (
    .clk(CLOCK),
    .rst_b(RST_B),
    .load_default(lane_load_default),
    .default_code(FUSE_LANE_MODE),
    .load_new(lane_load_new),
    .new_code(wr_sel),
    .code(ACTIVE_LANE_MODE)
  );

  assign REG_RDATA = rdata_reg;
  // tells neighbouring register banks to drop their serial writes too
  assign DEFAULTS_RESTORE = clear_writes;
endmodule
